// File: mpog_top.sv
// mpog_top: output polarity, level buffer and brushless gating for the six pwm pins
`timescale 1ns/1ns
// Functional notes
// - positive pins: select 0 active low, inverted by 1
// - reverse pins: select 0 active low, opposite compare sense
// - reverse pins stay initial until dead time ends, except under gating with the reverse group at static level
// - six-bit level buffer feeds output_control_two levels
// - buffer bits 7 and 6 read zero
// - gating only in complementary or reset-sync mode
// - gate bit 7 always reads one
// - brushless enable turns gating on
// - reverse group: static level or pwm
// - positive group: static level or pwm
// - feedback select: capture inputs or software bits
// - software phase bits replace feedback when selected
// - phase code table picks two pins, none for codes 000 and 111
// - per-pin levels only when select bit set
// - buffer copied at crest, trough or clear
module mpog_top
  import mpog_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_N_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // timer core events
  input  wire logic [1:0]  TIMER_MODE_IN,
  input  wire logic        COUNTING_IN,
  input  wire logic        DEAD_TIME_DONE_IN,
  input  wire logic [2:0]  UP_MATCH_IN,
  input  wire logic [2:0]  DOWN_MATCH_IN,
  input  wire logic        CREST_IN,
  input  wire logic        TROUGH_IN,
  input  wire logic        COUNTER_CLEAR_IN,
  input  wire logic [2:0]  CAPTURE_FEEDBACK_IN,
  // gate driver pins
  output logic             U_POSITIVE_PIN_OUT,
  output logic             V_POSITIVE_PIN_OUT,
  output logic             W_POSITIVE_PIN_OUT,
  output logic             U_REVERSE_PIN_OUT,
  output logic             V_REVERSE_PIN_OUT,
  output logic             W_REVERSE_PIN_OUT
);

  logic [2:0]  output_control_one;
  logic [7:0]  output_control_two;
  logic [5:0]  output_level_buffer;
  logic [6:0]  motor_gate_control;
  logic [2:0]  pos_on;
  logic        rev_ok;
  logic [5:0]  pin_q;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;

  mpog_mode_t  mode;
  logic        setup_ph;
  logic        wr_acc;
  logic        gate_live;
  logic        xfer;
  logic [5:0]  pwm_on;
  logic [5:0]  pwm_mask;
  logic [5:0]  next_drive;
  logic [31:0] next_rdata;
  logic        next_err;

  mpog_pin_if pin (.clk(MCLK_IN), .rst_n(RESET_N_IN));

  mpog_phase_sel u_phase_sel (
    .pin (pin)
  );

  mpog_level_map u_level_map (
    .pin (pin)
  );

  // timer mode decode
  always_comb begin
    case (TIMER_MODE_IN)
      MODE_CODE_COMP:  mode = MODE_COMP;
      MODE_CODE_RSYNC: mode = MODE_RSYNC;
      default:         mode = MODE_OTHER;
    endcase
  end

  // apb phases; a write lands only on the access edge that sees pready
  assign setup_ph = PSEL_IN & ~PENABLE_IN;
  assign wr_acc   = PSEL_IN & PENABLE_IN & pready & PWRITE_IN;

  always_comb begin
    xfer = 1'b0;
    if (mode == MODE_COMP) begin
      xfer = (output_control_two[CT2_BF_LSB] & CREST_IN)
           | (output_control_two[CT2_BF_LSB+1] & TROUGH_IN);
    end else if (mode == MODE_RSYNC) begin
      xfer = (output_control_two[CT2_BF_LSB+1 -: 2] == BF_CREST) & COUNTER_CLEAR_IN;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      output_control_one <= CT1_RST[2:0];
    end else if (wr_acc && PADDR_IN == ADDR_CTRL_ONE) begin
      output_control_one <= PWDATA_IN[2:0];
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      output_control_two <= CT2_RST;
    end else begin
      if (wr_acc && PADDR_IN == ADDR_CTRL_TWO) begin
        output_control_two <= PWDATA_IN[7:0];
      end
      // a hardware copy outranks a software write of the same bits
      if (xfer) begin
        output_control_two[5:0] <= output_level_buffer;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      output_level_buffer <= BUF_RST[5:0];
    end else if (wr_acc && PADDR_IN == ADDR_LVL_BUF) begin
      output_level_buffer <= PWDATA_IN[5:0];
    end
  end

  // bit 7 is not stored, it reads as a constant one
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      motor_gate_control <= GATE_RST[6:0];
    end else if (wr_acc && PADDR_IN == ADDR_GATE) begin
      motor_gate_control <= PWDATA_IN[6:0];
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN || !COUNTING_IN) begin
      pos_on <= 3'h0;
    end else begin
      pos_on <= (pos_on | UP_MATCH_IN) & ~DOWN_MATCH_IN;
    end
  end

  // reverse pwm requests held at initial level through dead time
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN || !COUNTING_IN) begin
      rev_ok <= 1'b0;
    end else if (DEAD_TIME_DONE_IN) begin
      rev_ok <= 1'b1;
    end
  end

  // reverse phase is active when positive is not
  always_comb begin
    pwm_on = 6'h00;
    for (int i = 0; i < 3; i++) begin
      pwm_on[2*i]   = pos_on[i];
      pwm_on[2*i+1] = rev_ok & ~pos_on[i];
    end
  end

  // gating ignored outside the two pwm modes
  assign gate_live = motor_gate_control[GT_BDC] & (mode != MODE_OTHER);

  // software phase bits substitute for capture inputs
  assign pin.phase_code = motor_gate_control[GT_FB] ? motor_gate_control[2:0]
                                                    : CAPTURE_FEEDBACK_IN;

  always_comb begin
    pwm_mask = ({6{motor_gate_control[GT_NPWM]}} & REV_MASK)
             | ({6{motor_gate_control[GT_PPWM]}} & POS_MASK);
    if (gate_live) begin
      next_drive = pin.phase_on & (pwm_on | ~pwm_mask);
    end else begin
      next_drive = pwm_on;
    end
  end
  assign pin.drive_active = next_drive;

  assign pin.level_sel = output_control_one[CT1_OUTPUT_CONTROL_SELECT] ? output_control_two[5:0]
                       : {3{output_control_one[CT1_OLSN], output_control_one[CT1_OLSP]}};

  // pins are registered so glitches in the gating mux never reach the drivers
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      pin_q <= 6'h3f;
    end else begin
      pin_q <= pin.pin_level;
    end
  end

  assign U_POSITIVE_PIN_OUT = pin_q[0];
  assign U_REVERSE_PIN_OUT  = pin_q[1];
  assign V_POSITIVE_PIN_OUT = pin_q[2];
  assign V_REVERSE_PIN_OUT  = pin_q[3];
  assign W_POSITIVE_PIN_OUT = pin_q[4];
  assign W_REVERSE_PIN_OUT  = pin_q[5];

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (PADDR_IN)
      ADDR_CTRL_ONE: next_rdata[2:0] = output_control_one;
      ADDR_CTRL_TWO: next_rdata[7:0] = output_control_two;
      ADDR_LVL_BUF:  next_rdata[5:0] = output_level_buffer;
      ADDR_GATE:     next_rdata[7:0] = {1'b1, motor_gate_control};
      ADDR_STATUS:   next_rdata[10:0] = {gate_live, rev_ok, pos_on, pin_q};
      default:       next_err = 1'b1;
    endcase
  end

  // answer is prepared on the setup edge, giving a zero-wait access phase
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pready  <= 1'b1;
      prdata  <= PWRITE_IN ? 32'h0 : next_rdata;
      pslverr <= next_err;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign PREADY_OUT  = pready;
  assign PRDATA_OUT  = prdata;
  assign PSLVERR_OUT = pslverr;

  property p_gate_bit7;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (setup_ph && !PWRITE_IN && PADDR_IN == ADDR_GATE) |=> (PRDATA_OUT[7] == 1'b1);
  endproperty
  a_gate_bit7: assert property (p_gate_bit7) else $error("gate bit 7 read as zero");

  property p_buf_high_zero;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (setup_ph && !PWRITE_IN && PADDR_IN == ADDR_LVL_BUF) |=> (PRDATA_OUT[7:6] == 2'h0);
  endproperty
  a_buf_high_zero: assert property (p_buf_high_zero) else $error("buffer bits 7:6 not zero");

  property p_crest_copy;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (mode == MODE_COMP && output_control_two[7:6] == BF_CREST && CREST_IN)
        |=> (output_control_two[5:0] == $past(output_level_buffer));
  endproperty
  a_crest_copy: assert property (p_crest_copy) else $error("crest copy missed");

  property p_no_copy;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (output_control_two[7:6] == BF_NONE && !wr_acc)
        |=> $stable(output_control_two[5:0]);
  endproperty
  a_no_copy: assert property (p_no_copy) else $error("levels changed with timing 00");

  property p_rev_hold;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (!rev_ok && !gate_live) |=> (pin_q[1] == ~$past(pin.level_sel[1])
                                 && pin_q[5] == ~$past(pin.level_sel[5]));
  endproperty
  a_rev_hold: assert property (p_rev_hold) else $error("reverse pin active in dead time");

  property p_common_level;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      !output_control_one[CT1_OUTPUT_CONTROL_SELECT]
        |-> (pin.level_sel[0] == output_control_one[CT1_OLSP]
             && pin.level_sel[3] == output_control_one[CT1_OLSN]);
  endproperty
  a_common_level: assert property (p_common_level) else $error("common level not used");

  property p_pos_active;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (!gate_live && pos_on[0]) |=> (U_POSITIVE_PIN_OUT == $past(pin.level_sel[0]));
  endproperty
  a_pos_active: assert property (p_pos_active) else $error("u positive not at active level");

  property p_sw_source;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (gate_live && motor_gate_control[GT_FB] && motor_gate_control[2:0] == 3'h0)
        |=> (pin_q == ~$past(pin.level_sel));
  endproperty
  a_sw_source: assert property (p_sw_source) else $error("software code 000 left a pin on");

  property p_mode_other;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (mode == MODE_OTHER) |-> (pin.drive_active == pwm_on);
  endproperty
  a_mode_other: assert property (p_mode_other) else $error("gating applied outside pwm modes");

  property p_down_clears;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (COUNTING_IN && DOWN_MATCH_IN[0]) |=> !pos_on[0];
  endproperty
  a_down_clears: assert property (p_down_clears) else $error("down match left u active");

  property p_count_stop;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      !COUNTING_IN |=> !rev_ok;
  endproperty
  a_count_stop: assert property (p_count_stop) else $error("reverse release kept at stop");

  property p_trough_copy;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (mode == MODE_COMP && output_control_two[CT2_BF_LSB+1] && TROUGH_IN)
        |=> (output_control_two[5:0] == $past(output_level_buffer));
  endproperty
  a_trough_copy: assert property (p_trough_copy) else $error("trough copy missed");

  property p_clear_copy;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (mode == MODE_RSYNC && output_control_two[7:6] == BF_CREST && COUNTER_CLEAR_IN)
        |=> (output_control_two[5:0] == $past(output_level_buffer));
  endproperty
  a_clear_copy: assert property (p_clear_copy) else $error("clear copy missed");

  property p_static_pos;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (gate_live && !motor_gate_control[GT_PPWM] && pin.phase_on[0])
        |=> (U_POSITIVE_PIN_OUT == $past(pin.level_sel[0]));
  endproperty
  a_static_pos: assert property (p_static_pos) else $error("static u positive not active");

  property p_static_rev;
    @(posedge MCLK_IN) disable iff (!RESET_N_IN)
      (gate_live && !motor_gate_control[GT_NPWM] && pin.phase_on[5])
        |=> (W_REVERSE_PIN_OUT == $past(pin.level_sel[5]));
  endproperty
  a_static_rev: assert property (p_static_rev) else $error("static w reverse not active");

endmodule

// File: mpog_pkg.sv
// mpog_pkg: register map, field positions, reset values and phase decode for the pwm output stage
package mpog_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_LVL_BUF  = 8'h08;
  localparam logic [7:0] ADDR_GATE     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;

  // output_control_one fields
  localparam int CT1_OUTPUT_CONTROL_SELECT = 2;
  localparam int CT1_OLSN = 1;
  localparam int CT1_OLSP = 0;
  // output_control_two fields
  localparam int CT2_BF_LSB = 6;
  // motor_gate_control fields
  localparam int GT_FIXED = 7;
  localparam int GT_BDC   = 6;
  localparam int GT_NPWM  = 5;
  localparam int GT_PPWM  = 4;
  localparam int GT_FB    = 3;

  // reset values
  localparam logic [7:0] CT1_RST  = 8'h00;
  localparam logic [7:0] CT2_RST  = 8'h00;
  localparam logic [7:0] BUF_RST  = 8'h00;
  localparam logic [7:0] GATE_RST = 8'h80;

  // buffer transfer timing codes
  localparam logic [1:0] BF_NONE  = 2'h0;
  localparam logic [1:0] BF_CREST = 2'h1;

  // timer mode input codes
  localparam logic [1:0] MODE_CODE_COMP  = 2'h1;
  localparam logic [1:0] MODE_CODE_RSYNC = 2'h2;

  // pin vector order: w_rev w_pos v_rev v_pos u_rev u_pos
  localparam logic [5:0] POS_MASK = 6'h15;
  localparam logic [5:0] REV_MASK = 6'h2a;

  typedef enum logic [2:0] {
    MODE_OTHER = 3'b001,
    MODE_COMP  = 3'b010,
    MODE_RSYNC = 3'b100
  } mpog_mode_t;

  // phase code is {w,v,u}; 000 and 111 switch everything off
  function automatic logic [5:0] mpog_phase_decode(input logic [2:0] code);
    case (code)
      3'h1:    mpog_phase_decode = 6'h21;
      3'h2:    mpog_phase_decode = 6'h06;
      3'h3:    mpog_phase_decode = 6'h24;
      3'h4:    mpog_phase_decode = 6'h18;
      3'h5:    mpog_phase_decode = 6'h09;
      3'h6:    mpog_phase_decode = 6'h12;
      default: mpog_phase_decode = 6'h00;
    endcase
  endfunction

endpackage

// File: mpog_pin_if.sv
// mpog_pin_if: phase decode and pin level signals shared by the output stage modules
`timescale 1ns/1ns
interface mpog_pin_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [2:0] phase_code;
  logic [5:0] phase_on;
  logic [5:0] level_sel;
  logic [5:0] drive_active;
  logic [5:0] pin_level;

  modport decode (input clk, rst_n, phase_code, output phase_on);
  modport map    (input clk, rst_n, level_sel, drive_active, output pin_level);
  modport core   (output phase_code, level_sel, drive_active, input phase_on, pin_level);
endinterface

// File: mpog_phase_sel.sv
// mpog_phase_sel: turns the three phase switch bits into six on/off pin requests
`timescale 1ns/1ns
module mpog_phase_sel
  import mpog_pkg::*;
(
  mpog_pin_if.decode pin
);

  assign pin.phase_on = mpog_phase_decode(pin.phase_code);

  property p_table_u;
    @(posedge pin.clk) disable iff (!pin.rst_n)
      (pin.phase_code == 3'h1) |-> (pin.phase_on == 6'h21);
  endproperty
  a_table_u: assert property (p_table_u) else $error("code 001 not u_pos and w_rev");

  property p_bad_code;
    @(posedge pin.clk) disable iff (!pin.rst_n)
      (pin.phase_code == 3'h7) |-> (pin.phase_on == 6'h00);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("code 111 left a pin on");

endmodule

// File: mpog_level_map.sv
// mpog_level_map: maps active/inactive requests to pin levels through the level-select bits
`timescale 1ns/1ns
module mpog_level_map (
  mpog_pin_if.map pin
);

  assign pin.pin_level = ~(pin.drive_active ^ pin.level_sel);

  property p_off_inactive;
    @(posedge pin.clk) disable iff (!pin.rst_n)
      (pin.drive_active == 6'h00) |-> (pin.pin_level == ~pin.level_sel);
  endproperty
  a_off_inactive: assert property (p_off_inactive) else $error("off pin not inactive");

endmodule

// File: mpog_drv_model.sv
// mpog_drv_model: gate driver and hall sensor model on the far side of the six pins
`timescale 1ns/1ns
module mpog_drv_model (
  // clock
  input  wire logic       clk_in,
  // rotor position commanded by the bench
  input  wire logic [2:0] sector_in,
  // gate pins, vector order w_rev w_pos v_rev v_pos u_rev u_pos
  input  wire logic [5:0] gate_in,
  // hall feedback to the capture inputs, and switches seen conducting
  output logic      [2:0] feedback_out,
  output logic      [5:0] on_out
);
  // hall edges arrive one clock late, like a real synchroniser
  always_ff @(posedge clk_in) begin
    feedback_out <= sector_in;
  end
  // drivers conduct on a low gate level; an unknown gate shows as unknown
  assign on_out = ~gate_in;
endmodule

// File: tb_top.sv
// tb_top: self-checking bench for the pwm output stage
`timescale 1ns/1ns
module tb_top;
  import mpog_pkg::*;
  logic        clk, rst_n, psel, pen, pwr, cnt, dead;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, err;
  logic [1:0]  mode;
  logic [2:0]  up, dn, ev, sector, fb;
  logic [5:0]  pv, on;
  int          fail_count, samples_checked;
  // expected conducting pins per phase code {w,v,u}
  logic [5:0]  tab [8] = '{6'h00, 6'h21, 6'h06, 6'h24, 6'h18, 6'h09, 6'h12, 6'h00};

  mpog_top dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TIMER_MODE_IN(mode), .COUNTING_IN(cnt),
    .DEAD_TIME_DONE_IN(dead), .UP_MATCH_IN(up), .DOWN_MATCH_IN(dn), .CREST_IN(ev[0]),
    .TROUGH_IN(ev[1]), .COUNTER_CLEAR_IN(ev[2]), .CAPTURE_FEEDBACK_IN(fb),
    .U_POSITIVE_PIN_OUT(pv[0]), .U_REVERSE_PIN_OUT(pv[1]), .V_POSITIVE_PIN_OUT(pv[2]),
    .V_REVERSE_PIN_OUT(pv[3]), .W_POSITIVE_PIN_OUT(pv[4]), .W_REVERSE_PIN_OUT(pv[5]));
  mpog_drv_model drv (.clk_in(clk), .sector_in(sector), .gate_in(pv),
    .feedback_out(fb), .on_out(on));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      $display("BAD %0t apb no ready", $time);
      wrap_up();
    end else begin
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, "read value");
  endtask

  // pins follow inputs through two flops
  task automatic pins(input logic [5:0] exp);
    repeat (3) @(posedge clk);
    chk(pv, exp, "pin levels");
  endtask

  task automatic t_reset();
    rd(ADDR_CTRL_ONE, 32'h0);
    rd(ADDR_CTRL_TWO, 32'h0);
    rd(ADDR_LVL_BUF, 32'h0);
    rd(ADDR_GATE, 32'h80);
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1, "unmapped error");
    pins(6'h3f);
    $display("test reset done");
  endtask

  task automatic t_regs();
    // software writes zero to buffer bits 7 and 6
    apb(1'b1, ADDR_LVL_BUF, 32'h3f);
    rd(ADDR_LVL_BUF, 32'h3f);
    apb(1'b1, ADDR_GATE, 32'hbf);
    rd(ADDR_GATE, 32'hbf);
    apb(1'b1, ADDR_GATE, 32'h80);
    $display("test regs done");
  endtask

  task automatic t_polar();
    logic [5:0] x;
    mode <= MODE_CODE_COMP;
    for (int s = 0; s < 2; s++) begin
      x = s ? 6'h3f : 6'h00;
      apb(1'b1, ADDR_CTRL_ONE, s ? 32'h3 : 32'h0);
      pins(~x);
      cnt <= 1'b1;
      pins(~x);
      dead <= 1'b1;
      @(posedge clk);
      dead <= 1'b0;
      pins((~x & 6'h15) | (x & 6'h2a));
      up <= 3'h1;
      @(posedge clk);
      up <= 3'h0;
      pins(((~x & 6'h15) | (x & 6'h2a)) ^ 6'h03);
      rd(ADDR_STATUS, {21'h0, 2'h1, 3'h1, ((~x & 6'h15) | (x & 6'h2a)) ^ 6'h03});
      dn <= 3'h1;
      @(posedge clk);
      dn <= 3'h0;
      pins((~x & 6'h15) | (x & 6'h2a));
      cnt <= 1'b0;
    end
    apb(1'b1, ADDR_CTRL_ONE, 32'h0);
    $display("test polarity done");
  endtask

  task automatic t_pinsel();
    apb(1'b1, ADDR_CTRL_TWO, 32'h15);
    pins(6'h3f);
    apb(1'b1, ADDR_CTRL_ONE, 32'h4);
    pins(6'h2a);
    apb(1'b1, ADDR_CTRL_ONE, 32'h0);
    $display("test level select done");
  endtask

  task automatic t_buf();
    // mode, timing code, event index (0 crest 1 trough 2 clear), copy expected
    logic [1:0] md [7] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1};
    logic [1:0] bf [7] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0};
    int         evi [7] = '{1, 0, 1, 0, 2, 2, 0};
    logic       hit [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [5:0] v;
    for (int i = 0; i < 7; i++) begin
      v = 6'h2a ^ 6'(i);
      mode <= md[i];
      apb(1'b1, ADDR_CTRL_TWO, {24'h0, bf[i], 6'h00});
      apb(1'b1, ADDR_LVL_BUF, {26'h0, v});
      @(posedge clk);
      ev <= 3'(1 << evi[i]);
      @(posedge clk);
      ev <= 3'h0;
      rd(ADDR_CTRL_TWO, {24'h0, bf[i], hit[i] ? v : 6'h00});
    end
    apb(1'b1, ADDR_CTRL_TWO, 32'h0);
    $display("test buffer done");
  endtask

  task automatic t_gate();
    mode <= MODE_CODE_COMP;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_GATE, 32'hc8 | c);
      pins(~tab[c]);
    end
    apb(1'b1, ADDR_GATE, 32'hc7);
    for (int c = 0; c < 8; c++) begin
      sector <= 3'(c);
      pins(~tab[c]);
      chk(on, tab[c], "drivers on");
    end
    sector <= 3'h0;
    apb(1'b1, ADDR_GATE, 32'hd9);
    pins(6'h1f);
    apb(1'b1, ADDR_GATE, 32'he9);
    pins(6'h3e);
    apb(1'b1, ADDR_GATE, 32'h89);
    pins(6'h3f);
    mode <= 2'h0;
    apb(1'b1, ADDR_GATE, 32'hc9);
    pins(6'h3f);
    mode <= 2'h3;
    pins(6'h3f);
    mode <= MODE_CODE_RSYNC;
    pins(6'h1e);
    $display("test gating done");
  endtask

  initial begin
    rst_n <= 1'b0; psel <= 1'b0; pen <= 1'b0; pwr <= 1'b0; paddr <= 8'h00;
    pwdata <= 32'h0; mode <= 2'h0; cnt <= 1'b0; dead <= 1'b0; up <= 3'h0;
    dn <= 3'h0; ev <= 3'h0; sector <= 3'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_polar();
    t_pinsel();
    t_buf();
    t_gate();
    wrap_up();
  end
endmodule
